// ### core/adc_card_defines.vh
`ifndef ADC_CARD_DEFINES_VH
`define ADC_CARD_DEFINES_VH
// ----------------------------------------
// Register offsets within the eight-byte window
// ----------------------------------------
`define OFS_LOW_DOUT    3'h0
`define OFS_HIGH_START  3'h1
`define OFS_STAT_CTRL1  3'h2
`define OFS_DIN_CTRL2   3'h3
`define OFS_CNT0        3'h4
`define OFS_CNT1        3'h5
`define OFS_CNT2        3'h6
`define OFS_CNT_CTRL    3'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPO_MSB         7
`define GPO_LSB         4
`define IEN_BIT         3
`define USER_BIT        3
`define CHAN_MSB        2
`define CHAN_LSB        0
`define GAIN_MSB        2
`define GAIN_LSB        0
`define BUSY_BIT        7
`define IRQF_BIT        3
`define SEL_MSB         7
`define SEL_LSB         6
`define ACC_MSB         5
`define ACC_LSB         4
`define FN_MSB          3
`define FN_LSB          1
`define BCD_BIT         0
// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define ACC_LATCH       2'h0
`define ACC_LOW         2'h1
`define ACC_HIGH        2'h2
`define ACC_BOTH        2'h3
`define SEL_READBACK    2'h3
`define RST_BYTE        8'h00
`define RST_NIB         4'h0
`define RST_TRI         3'h0
`define RST_RESULT      12'h000
`define RST_COUNT       16'h0000
`define RST_FN          3'h0
`define UNUSED_READ     8'h00
`endif

// ### core/adc_conv_ctrl.v
`timescale 1ns/1ps
`include "adc_card_defines.vh"
module adc_conv_ctrl (
    // Clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Host side
    input  wire        start_i,
    output reg         busy_o,
    output reg  [11:0] result_o,
    output reg         complete_o,
    // Converter side
    output reg         conv_start_o,
    input  wire        adc_done_i,
    input  wire [11:0] adc_data_i
);
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_o       <= 1'b0;
            result_o     <= `RST_RESULT;
            complete_o   <= 1'b0;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= start_i;
            complete_o   <= 1'b0;
            if (start_i) begin
                busy_o <= 1'b1;
            end else if (adc_done_i && busy_o) begin
                busy_o     <= 1'b0;
                result_o   <= adc_data_i;
                complete_o <= 1'b1;
            end
        end
    end
endmodule

// ### core/counter_access.v
`timescale 1ns/1ps
`include "adc_card_defines.vh"
module counter_access (
    // Clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Host byte port
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire        ctrl_wr_i,
    input  wire [1:0]  sel_i,
    input  wire [7:0]  data_i,
    output reg  [7:0]  rd_byte_o,
    // Counter cores
    input  wire [47:0] count_i,
    output reg  [2:0]  load_o,
    output reg  [47:0] load_value_o,
    output reg  [8:0]  function_code_o,
    output reg  [2:0]  bcd_o
);
    reg [1:0]  acc_reg   [0:2];
    reg [7:0]  hold_reg  [0:2];
    reg [15:0] latch_reg [0:2];
    reg [2:0]  wr_hi_reg, rd_hi_reg, latched_reg;
    reg [15:0] src;
    integer    i;
    wire [1:0] csel = data_i[`SEL_MSB:`SEL_LSB];
    wire [1:0] cacc = data_i[`ACC_MSB:`ACC_LSB];

    // Top bit of the function code does not matter for modes 2 and 3
    function [2:0] norm_fn;
        input [2:0] fn;
        begin
            norm_fn = fn[1] ? {1'b0, fn[1:0]} : fn;
        end
    endfunction

    always @* begin
        src = latched_reg[sel_i] ? latch_reg[sel_i] : count_i[16*sel_i +: 16];
        rd_byte_o = src[7:0];
        if (acc_reg[sel_i] == `ACC_HIGH || (acc_reg[sel_i] == `ACC_BOTH && rd_hi_reg[sel_i])) begin
            rd_byte_o = src[15:8];
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (i = 0; i < 3; i = i + 1) begin
                acc_reg[i]   <= `ACC_BOTH;
                hold_reg[i]  <= `RST_BYTE;
                latch_reg[i] <= `RST_COUNT;
            end
            wr_hi_reg       <= `RST_TRI;
            rd_hi_reg       <= `RST_TRI;
            latched_reg     <= `RST_TRI;
            load_o          <= `RST_TRI;
            load_value_o    <= {3{`RST_COUNT}};
            function_code_o <= {3{`RST_FN}};
            bcd_o           <= `RST_TRI;
        end else begin
            load_o <= `RST_TRI;
            // route control byte; read-back is accepted and ignored
            if (ctrl_wr_i && csel != `SEL_READBACK) begin
                if (cacc == `ACC_LATCH) begin
                    latch_reg[csel]   <= count_i[16*csel +: 16];
                    latched_reg[csel] <= 1'b1;
                end else begin
                    acc_reg[csel]                <= cacc;
                    function_code_o[3*csel +: 3] <= norm_fn(data_i[`FN_MSB:`FN_LSB]);
                    bcd_o[csel]                  <= data_i[`BCD_BIT];
                    wr_hi_reg[csel]              <= 1'b0;
                    rd_hi_reg[csel]              <= 1'b0;
                    latched_reg[csel]            <= 1'b0;
                end
            end
            if (wr_i) begin
                if (acc_reg[sel_i] == `ACC_BOTH && !wr_hi_reg[sel_i]) begin
                    hold_reg[sel_i]  <= data_i;
                    wr_hi_reg[sel_i] <= 1'b1;
                end else begin
                    load_o[sel_i]                <= 1'b1;
                    wr_hi_reg[sel_i]             <= 1'b0;
                    load_value_o[16*sel_i +: 16] <= (acc_reg[sel_i] == `ACC_HIGH) ? {data_i, `RST_BYTE} :
                                                    (acc_reg[sel_i] == `ACC_BOTH) ? {data_i, hold_reg[sel_i]} :
                                                    {`RST_BYTE, data_i};
                end
            end
            if (rd_i) begin
                if (acc_reg[sel_i] == `ACC_BOTH) begin
                    rd_hi_reg[sel_i] <= ~rd_hi_reg[sel_i];
                    if (rd_hi_reg[sel_i]) begin
                        latched_reg[sel_i] <= 1'b0;
                    end
                end else begin
                    latched_reg[sel_i] <= 1'b0;
                end
            end
        end
    end
endmodule

// ### core/adc_card_io_registers.v
// Operation
// - eight byte addresses, separate read/write functions
// - offset 2 write: outputs, enable, channel
// - interrupts only while enable bit set
// - channel field picks one of eight
// - both control writes update general outputs
// - offset 3 write: user bit, gain
// - gain lines encode eight gain settings
// - offset 2 read: busy, gain, flag, channel
// - busy high during conversion, low when valid
// - flag set on interrupt, cleared by control or start writes
// - any offset 1 write starts conversion
// - result latched at end, held till next
// - offset 0 read: low nibble, general outputs
// - offset 1 read: result high byte
// - digital output write, digital input read
// - line direction from static configuration input
// - counters loaded and read bytewise
// - offset 7 write: counter control byte
// - transfer type decode latch/low/high/both
// - mode field selects modes zero to five
// - bit 0 picks binary or decimal
// - select 00 addresses counter zero
`timescale 1ns/1ps
`include "adc_card_defines.vh"
module adc_card_io_registers (
    // Clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Host I/O bus
    input  wire [9:0]  addr_i,
    input  wire        aen_i,
    input  wire        iow_i,
    input  wire        ior_i,
    input  wire [7:0]  wr_data_i,
    output reg  [7:0]  rd_data_o,
    output reg         rd_valid_o,
    output reg         irq_o,
    // Board configuration
    input  wire [6:0]  board_base_i,
    input  wire [7:0]  port_line_direction_i,
    // Card outputs
    output reg  [3:0]  general_output_lines_o,
    output reg  [2:0]  channel_select_o,
    output reg  [2:0]  gain_select_lines_o,
    output reg         user_output_o,
    // Digital port
    input  wire [7:0]  input_port_bits_i,
    output reg  [7:0]  digital_output_bits_o,
    output reg  [7:0]  port_line_oe_o,
    // Converter
    output wire        conv_start_o,
    input  wire        adc_done_i,
    input  wire [11:0] adc_data_i,
    // Counter cores
    input  wire [47:0] counter_count_i,
    output wire [2:0]  counter_load_o,
    output wire [47:0] counter_load_value_o,
    output wire [8:0]  counter_function_code_o,
    output wire [2:0]  counter_bcd_o
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire       board_hit;
    wire [2:0] ofs;
    wire       wr_hit;
    wire       rd_hit;

    // DMA cycles drive the address bus too, so aen_i blocks the decode
    // eight-byte window
    assign board_hit = !aen_i && (addr_i[9:3] == board_base_i);
    assign ofs       = addr_i[2:0];
    assign wr_hit    = iow_i && board_hit;
    assign rd_hit    = ior_i && board_hit;

    // Helpers take every operand as an argument so continuous assignments track them
    function is_write;
        input       hit;
        input [2:0] o;
        input [2:0] want;
        begin
            is_write = hit && (o == want);
        end
    endfunction

    function is_counter;
        input [2:0] o;
        begin
            is_counter = (o == `OFS_CNT0) || (o == `OFS_CNT1) || (o == `OFS_CNT2);
        end
    endfunction

    wire wr_dout  = is_write(wr_hit, ofs, `OFS_LOW_DOUT);
    wire wr_start = is_write(wr_hit, ofs, `OFS_HIGH_START);
    wire wr_ctrl1 = is_write(wr_hit, ofs, `OFS_STAT_CTRL1);
    wire wr_ctrl2 = is_write(wr_hit, ofs, `OFS_DIN_CTRL2);
    wire wr_cctl  = is_write(wr_hit, ofs, `OFS_CNT_CTRL);
    wire wr_cnt   = wr_hit && is_counter(ofs);
    wire rd_cnt   = rd_hit && is_counter(ofs);
    wire ctrl_any = wr_ctrl1 || wr_ctrl2;

    // Offsets 4..6 map onto counters 0..2 through the low two address bits;
    // elsewhere the select parks on counter 0 so the counter mux stays in range
    wire [1:0] cnt_sel = is_counter(ofs) ? ofs[1:0] : 2'h0;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    wire        busy;
    wire [11:0] result;
    wire        conv_complete;

    // A start while busy restarts; a done on the start clock is dropped, but any later done while busy is taken as the result
    // start on any data
    adc_conv_ctrl u_conv (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .start_i      (wr_start),
        .busy_o       (busy),
        .result_o     (result),
        .complete_o   (conv_complete),
        .conv_start_o (conv_start_o),
        .adc_done_i   (adc_done_i),
        .adc_data_i   (adc_data_i)
    );

    // ----------------------------------------
    // Counter access port
    // ----------------------------------------
    wire [7:0] cnt_byte;

    // Read-back commands are accepted and dropped; no status byte is returned
    // control byte delivery
    counter_access u_cnt (
        .clk_i           (clk_i),
        .sys_rst_i       (sys_rst_i),
        .wr_i            (wr_cnt),
        .rd_i            (rd_cnt),
        .ctrl_wr_i       (wr_cctl),
        .sel_i           (cnt_sel),
        .data_i          (wr_data_i),
        .rd_byte_o       (cnt_byte),
        .count_i         (counter_count_i),
        .load_o          (counter_load_o),
        .load_value_o    (counter_load_value_o),
        .function_code_o (counter_function_code_o),
        .bcd_o           (counter_bcd_o)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [3:0] gpo_reg, gpo_next;
    reg       allow_reg, allow_next;
    reg [2:0] chan_reg, chan_next;
    reg [2:0] gain_reg, gain_next;
    reg       user_reg, user_next;
    reg [7:0] dout_reg, dout_next;

    // Offset 0 writes load only the digital port, never the shared outputs
    always @* begin
        gpo_next   = gpo_reg;
        allow_next = allow_reg;
        chan_next  = chan_reg;
        gain_next  = gain_reg;
        user_next  = user_reg;
        dout_next  = dout_reg;
        if (ctrl_any) begin
            gpo_next = wr_data_i[`GPO_MSB:`GPO_LSB];
        end
        if (wr_ctrl1) begin
            allow_next = wr_data_i[`IEN_BIT];
            chan_next  = wr_data_i[`CHAN_MSB:`CHAN_LSB];
        end
        if (wr_ctrl2) begin
            user_next = wr_data_i[`USER_BIT];
            gain_next = wr_data_i[`GAIN_MSB:`GAIN_LSB];
        end
        if (wr_dout) begin
            dout_next = wr_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            gpo_reg   <= `RST_NIB;
            allow_reg <= 1'b0;
            chan_reg  <= `RST_TRI;
            gain_reg  <= `RST_TRI;
            user_reg  <= 1'b0;
            dout_reg  <= `RST_BYTE;
        end else begin
            gpo_reg   <= gpo_next;
            allow_reg <= allow_next;
            chan_reg  <= chan_next;
            gain_reg  <= gain_next;
            user_reg  <= user_next;
            dout_reg  <= dout_next;
        end
    end

    // ----------------------------------------
    // Interrupt flag and request
    // ----------------------------------------
    reg irq_flag_reg, irq_flag_next;
    reg irq_set;
    reg irq_clr;

    // Flag and pin follow the completion pulse, one clock after busy drops;
    // software polling busy may see busy 0 with the flag still 0 for that clock
    always @* begin
        irq_set = conv_complete && allow_reg;
        // cleared by control write or start
        irq_clr = ctrl_any || wr_start;
        // A completion landing on a clearing write still counts
        irq_flag_next = irq_set || (irq_flag_reg && !irq_clr);
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_flag_reg <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            irq_flag_reg <= irq_flag_next;
            irq_o        <= irq_flag_next && allow_next;
        end
    end

    // ----------------------------------------
    // Read byte assembly
    // ----------------------------------------
    wire [7:0] low_byte;
    wire [7:0] high_byte;
    wire [7:0] status_byte;

    assign low_byte    = {result[3:0], gpo_reg};
    assign high_byte   = result[11:4];
    assign status_byte = {busy, gain_reg, irq_flag_reg, chan_reg};

    // ----------------------------------------
    // Read data path
    // ----------------------------------------
    reg [7:0] rd_mux;

    always @* begin
        case (ofs)
            `OFS_LOW_DOUT: begin
                rd_mux = low_byte;
            end
            `OFS_HIGH_START: begin
                rd_mux = high_byte;
            end
            `OFS_STAT_CTRL1: begin
                rd_mux = status_byte;
            end
            `OFS_DIN_CTRL2: begin
                rd_mux = input_port_bits_i;
            end
            `OFS_CNT0, `OFS_CNT1, `OFS_CNT2: begin
                rd_mux = cnt_byte;
            end
            default: begin
                rd_mux = `UNUSED_READ;
            end
        endcase
    end

    // Read data is presented one clock after the strobe and then held
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_o  <= `RST_BYTE;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_hit;
            if (rd_hit) begin
                rd_data_o <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    // Pins load from the next-state values, so they change on the same edge as the registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            general_output_lines_o <= `RST_NIB;
            user_output_o          <= 1'b0;
        end else begin
            general_output_lines_o <= gpo_next;
            user_output_o          <= user_next;
        end
    end

    // ----------------------------------------
    // Analog front-end pins
    // ----------------------------------------
    // Nothing holds off a channel or gain change during a conversion; software waits for busy
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_select_o    <= `RST_TRI;
            gain_select_lines_o <= `RST_TRI;
        end else begin
            channel_select_o    <= chan_next;
            gain_select_lines_o <= gain_next;
        end
    end

    // ----------------------------------------
    // Digital port
    // ----------------------------------------
    // Direction straps are static, so one register stage is all they need
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            digital_output_bits_o <= `RST_BYTE;
            port_line_oe_o        <= `RST_BYTE;
        end else begin
            digital_output_bits_o <= dout_next;
            port_line_oe_o        <= port_line_direction_i;
        end
    end
endmodule

// ### dv/adc_card_io_registers_props.sv
`timescale 1ns/1ps
module adc_card_io_registers_props (
    // Clock and reset
    input  wire       clk_i,
    input  wire       sys_rst_i,
    // Host bus
    input  wire [9:0] addr_i,
    input  wire       aen_i,
    input  wire       iow_i,
    input  wire       ior_i,
    input  wire [7:0] wr_data_i,
    input  wire [7:0] rd_data_o,
    input  wire       rd_valid_o,
    input  wire       irq_o,
    // Configuration and outputs
    input  wire [6:0] board_base_i,
    input  wire [7:0] port_line_direction_i,
    input  wire [3:0] general_output_lines_o,
    input  wire [2:0] channel_select_o,
    input  wire [2:0] gain_select_lines_o,
    input  wire       user_output_o,
    input  wire [7:0] digital_output_bits_o,
    input  wire [7:0] port_line_oe_o,
    input  wire       conv_start_o
);
    wire       hit = !aen_i && addr_i[9:3] == board_base_i;
    wire       w   = iow_i && hit;
    wire       r   = ior_i && hit;
    wire [2:0] o   = addr_i[2:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_read_answer: assert property (r |=> rd_valid_o)
        else $error("read not answered");
    chk_no_phantom: assert property (!r |=> !rd_valid_o)
        else $error("unexpected read valid");
    chk_unused_read: assert property (r && o == 3'h7 |=> rd_data_o == 8'h00)
        else $error("offset 7 read not zero");
    chk_chan_write: assert property (w && o == 3'h2 |=> channel_select_o == $past(wr_data_i[2:0]))
        else $error("channel not loaded");
    chk_shared_outputs: assert property (w && (o == 3'h2 || o == 3'h3)
        |=> general_output_lines_o == $past(wr_data_i[7:4]))
        else $error("general outputs not loaded");
    chk_gain_user: assert property (w && o == 3'h3
        |=> {user_output_o, gain_select_lines_o} == $past(wr_data_i[3:0]))
        else $error("gain or user bit not loaded");
    chk_enable_off: assert property (w && o == 3'h2 && !wr_data_i[3] |=> !irq_o)
        else $error("interrupt while disabled");
    chk_start_pulse: assert property (w && o == 3'h1 |=> conv_start_o ##1 (!conv_start_o || $past(w && o == 3'h1)))
        else $error("start pulse wrong");
    chk_dout_load: assert property (w && o == 3'h0 |=> digital_output_bits_o == $past(wr_data_i))
        else $error("digital outputs not loaded");
    chk_dir_follow: assert property (!$past(sys_rst_i)
        |-> port_line_oe_o == $past(port_line_direction_i))
        else $error("line enables differ from configuration");
    cover property (w && o == 3'h1);
    cover property (r && o == 3'h1);
    cover property (w && o == 3'h7);
endmodule
bind adc_card_io_registers adc_card_io_registers_props u_props (
    .clk_i, .sys_rst_i, .addr_i, .aen_i, .iow_i, .ior_i, .wr_data_i, .rd_data_o, .rd_valid_o,
    .irq_o, .board_base_i, .port_line_direction_i, .general_output_lines_o, .channel_select_o,
    .gain_select_lines_o, .user_output_o, .digital_output_bits_o, .port_line_oe_o, .conv_start_o
);

// ### dv/adc_conv_model.sv
`timescale 1ns/1ps
module adc_conv_model (
    // Clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Card side
    input  wire        conv_start_i,
    input  wire [7:0]  delay_i,
    input  wire [11:0] sample_i,
    output logic       adc_done_o,
    output logic [11:0] adc_data_o
);
    int left;
    always @(posedge clk_i) begin
        adc_done_o <= 1'b0;
        adc_data_o <= ~adc_data_o;
        if (sys_rst_i) begin
            left       <= 0;
            adc_data_o <= 12'h000;
        end else if (conv_start_i) begin
            left <= delay_i;
        end else if (left == 1) begin
            adc_done_o <= 1'b1;
            adc_data_o <= sample_i;
            left       <= 0;
        end else if (left > 1) begin
            left <= left - 1;
        end
    end
endmodule

// ### dv/adc_card_io_registers_test.sv
`timescale 1ns/1ps
module adc_card_io_registers_test;
    logic        clk_i = 0, sys_rst_i = 1, aen_i = 0, iow_i = 0, ior_i = 0;
    logic [9:0]  addr_i = 10'h000;
    logic [7:0]  wr_data_i = 8'h00, port_line_direction_i = 8'h0f, input_port_bits_i = 8'hc3;
    logic [7:0]  dly = 8'h14;
    logic [6:0]  board_base_i = 7'h60, tgt = 7'h60;
    logic [47:0] counter_count_i = 48'hc2c1_b2b1_a2a1;
    logic [11:0] sample = 12'habc;
    wire  [7:0]  rd_data_o, digital_output_bits_o, port_line_oe_o;
    wire         rd_valid_o, irq_o, user_output_o, conv_start_o, adc_done_i;
    wire  [3:0]  general_output_lines_o;
    wire  [2:0]  channel_select_o, gain_select_lines_o, counter_load_o, counter_bcd_o;
    wire  [11:0] adc_data_i;
    wire  [47:0] counter_load_value_o;
    wire  [8:0]  counter_function_code_o;
    int          mismatches = 0, total_checks = 0, i, n;
    adc_card_io_registers u_dut (
        .clk_i, .sys_rst_i, .addr_i, .aen_i, .iow_i, .ior_i, .wr_data_i, .rd_data_o, .rd_valid_o,
        .irq_o, .board_base_i, .port_line_direction_i, .general_output_lines_o, .channel_select_o,
        .gain_select_lines_o, .user_output_o, .input_port_bits_i, .digital_output_bits_o,
        .port_line_oe_o, .conv_start_o, .adc_done_i, .adc_data_i, .counter_count_i,
        .counter_load_o, .counter_load_value_o, .counter_function_code_o, .counter_bcd_o
    );
    adc_conv_model u_conv (
        .clk_i, .sys_rst_i, .conv_start_i(conv_start_o), .delay_i(dly), .sample_i(sample),
        .adc_done_o(adc_done_i), .adc_data_o(adc_data_i)
    );
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ----
    // Host access tasks
    // ----
    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] o, logic [7:0] d);
        @(posedge clk_i);
        #1 addr_i = {tgt, o};
        wr_data_i = d;
        iow_i = 1;
        @(posedge clk_i);
        #1 iow_i = 0;
    endtask
    task automatic rd(logic [2:0] o, logic [7:0] exp, string name);
        @(posedge clk_i);
        #1 addr_i = {tgt, o};
        ior_i = 1;
        @(posedge clk_i);
        #1 ior_i = 0;
        check("rd_valid", rd_valid_o, 1);
        check(name, rd_data_o, exp);
    endtask
    task automatic wait_for(input bit want_irq);
        i = 0;
        while ((want_irq ? irq_o : adc_done_i) !== 1'b1 && i < 100) begin
            @(posedge clk_i);
            #1 i++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        close_out();
    end
    // ----
    // Test sequence
    // ----
    initial begin
        repeat (10) @(posedge clk_i);
        #1 sys_rst_i = 0;
        check("outs", {general_output_lines_o, channel_select_o, gain_select_lines_o, irq_o}, 0);
        rd(3'h7, 8'h00, "unused");
        wr(3'h2, 8'ha5);
        check("chan", channel_select_o, 3'h5);
        wr(3'h3, 8'h3e);
        check("gain_user", {user_output_o, gain_select_lines_o}, 4'he);
        check("gpo", general_output_lines_o, 4'h3);
        rd(3'h2, 8'h65, "status");
        wr(3'h0, 8'h5c);
        check("dout", {digital_output_bits_o, general_output_lines_o}, 12'h5c3);
        rd(3'h3, 8'hc3, "din");
        check("oe", port_line_oe_o, 8'h0f);
        port_line_direction_i = 8'h5a;
        @(posedge clk_i);
        #1 check("oe2", port_line_oe_o, 8'h5a);
        aen_i = 1;
        wr(3'h2, 8'h00);
        aen_i = 0;
        tgt = 7'h61;
        wr(3'h2, 8'h00);
        tgt = board_base_i;
        check("miss", channel_select_o, 3'h5);
        $display("test registers done");
        wr(3'h2, 8'h0a);
        wr(3'h1, 8'hff);
        rd(3'h2, 8'he2, "busy");
        wait_for(1'b1);
        check("irq", irq_o, 1);
        rd(3'h0, 8'hc0, "res_low");
        rd(3'h1, 8'hab, "res_high");
        rd(3'h2, 8'h6a, "flag");
        wr(3'h3, 8'h06);
        check("irq_clr", irq_o, 0);
        rd(3'h2, 8'h62, "flag_clr");
        wr(3'h2, 8'h02);
        sample = 12'h123;
        dly = 8'h01;
        wr(3'h1, 8'h00);
        wait_for(1'b0);
        repeat (2) @(posedge clk_i);
        #1 check("irq_off", irq_o, 0);
        rd(3'h2, 8'h62, "no_flag");
        rd(3'h0, 8'h30, "low2");
        rd(3'h1, 8'h12, "high2");
        $display("test conversion done");
        for (n = 0; n < 8; n++) begin
            wr(3'h7, {4'b0011, n[2:0], 1'b0});
            check("fn", counter_function_code_o[2:0], n > 5 ? n - 4 : n);
        end
        for (n = 0; n < 3; n++) begin
            wr(3'h7, {n[1:0], 6'b110001});
            check("bcd", counter_bcd_o[n], 1);
            wr(3'(4 + n), 8'h34);
            wr(3'(4 + n), 8'h12);
            check("load", {counter_load_o[n], counter_load_value_o[16*n+:16]}, 17'h11234);
            rd(3'(4 + n), counter_count_i[16*n+:8], "cnt_low");
            rd(3'(4 + n), counter_count_i[16*n+8+:8], "cnt_high");
        end
        wr(3'h7, 8'h50);
        wr(3'h5, 8'h77);
        check("ld_low", counter_load_value_o[31:16], 16'h0077);
        wr(3'h7, 8'ha0);
        wr(3'h6, 8'h88);
        check("ld_high", counter_load_value_o[47:32], 16'h8800);
        wr(3'h7, 8'hfe);
        check("readback", {counter_function_code_o, counter_bcd_o}, 12'h001);
        wr(3'h7, 8'h00);
        counter_count_i[15:0] = 16'h5555;
        rd(3'h4, 8'ha1, "latch_low");
        rd(3'h4, 8'ha2, "latch_high");
        rd(3'h4, 8'h55, "live");
        $display("test counters done");
        close_out();
    end
endmodule
